// ==== tb/mpe_host_model.sv ====
// Initiator model streaming mode select pages
`timescale 1ns/1ps
module mpe_host_model (
    input wire logic sys_clk,
    input wire logic selDone,
    input wire logic selReject,
    output logic selValid,
    output logic [7:0] selByte,
    output logic selLast,
    output logic selPageFormat
);
    initial begin
        selValid = 1'b0;
        selByte = 8'h00;
        selLast = 1'b0;
        selPageFormat = 1'b0;
    end
    // One byte per edge, then wait a bounded time for the verdict
    task automatic send(input logic [7:0] p[12], input int n, input logic pf, output logic rej);
        rej = 1'bx;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            selValid <= 1'b1;
            selByte <= p[i];
            selLast <= (i == n - 1);
            selPageFormat <= pf;
        end
        @(posedge sys_clk);
        selValid <= 1'b0;
        selLast <= 1'b0;
        // Released byte lane shows garbage, not the last value
        selByte <= ~p[n - 1];
        repeat (4) begin
            @(posedge sys_clk);
            #1 if (selDone === 1'b1) rej = selReject;
        end
    endtask : send
endmodule : mpe_host_model

// ==== tb/test_mpe_mode_pages.sv ====
// Self-checking bench for the mode page engine
`timescale 1ns/1ps
module test_mpe_mode_pages;
    import mpe_pkg::*;
    logic sys_clk, sys_rst, regWr, regRd, senseReq, bot, writeErr, writeBlockDone, rej, s;
    logic selValid, selLast, selPageFormat, selDone, selReject, senseValid, writeSkip, noDisconnect, written_without_retries_flag;
    logic [3:0] regAddr, senseKey;
    logic [5:0] senseCode;
    logic [7:0] selByte, senseByte, rr, wrl, fill, empty, bufFree, sb[12];
    logic [15:0] burstSize;
    logic readErr, readRetry, dataPhase, xferStrobe, busReleased, disconnectReq, reconnectReq;
    logic [31:0] regWrData, regRdData, rd;
    int errors, checks_done, n;
    mpe_mode_pages #(.RESEL_CYCLES(20)) i_dut (.sys_clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .selValid, .selByte, .selLast, .selPageFormat, .selDone, .selReject, .senseKey,
        .senseReq, .senseCode, .senseValid, .senseByte, .senseLast(), .senseReject(),
        .logicalBeginningOfTape(bot), .readErr, .readOk(1'b0), .readRetry, .readFatal(),
        .writeErr, .writeBlockDone, .writeRewrite(), .writeSkip, .writeFatal(), .dataPhase,
        .dirRead(1'b0), .xferStrobe, .bufFill(8'h00), .bufFree, .busReleased,
        .reselDone(1'b0), .disconnectReq, .reconnectReq, .readRetryLimit(rr), .writeRetryLimit(wrl),
        .fillThreshold(fill), .emptyThreshold(empty), .burstSize, .noDisconnect, .writtenWithoutRetries(written_without_retries_flag));
    mpe_host_model i_host (.sys_clk, .selDone, .selReject, .selValid, .selByte, .selLast, .selPageFormat);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic summarize();
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic pulse(input logic [3:0] a, input logic w);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= 32'h1;
        regWr <= w;
        regRd <= ~w;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 rd = regRdData;
    endtask : pulse
    // Page bytes padded to twelve; expected reject flag
    task automatic pg(input logic [7:0] p[12], input int k, input logic pf, input logic e);
        i_host.send(p, k, pf, rej);
        chk(rej, e);
    endtask : pg
    initial begin
        #2000000 errors++;
        summarize();
    end
    initial begin
        {sys_rst, bot} = 2'b11;
        {regWr, regRd, senseReq, writeErr, writeBlockDone, regAddr, regWrData, senseCode} = '0;
        {readErr, dataPhase, xferStrobe, busReleased, bufFree} = '0;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk({rr, wrl, fill, empty}, 32'h0B0B8080);
        chk({burstSize, noDisconnect}, 0);
        pg('{8'h01, 8'h07, 0, 8'h05, 0, 0, 0, 0, 8'h00, 0, 0, 0}, 9, 1, 0);
        chk({rr, wrl}, 16'h0500);
        @(posedge sys_clk) writeErr <= 1'b1;
        @(posedge sys_clk) writeErr <= 1'b0;
        #1 s = writeSkip;
        @(posedge sys_clk) writeBlockDone <= 1'b1;
        #1 s |= writeSkip;
        chk(s, 1);
        @(posedge sys_clk) writeBlockDone <= 1'b0;
        pulse(OFS_STATUS, 0);
        chk({written_without_retries_flag, rd[STAT_WWR_BIT]}, 2'b11);
        pg('{8'h01, 8'h07, 0, 8'h0B, 0, 0, 0, 0, 8'h03, 0, 0, 0}, 9, 1, 0);
        @(posedge sys_clk) bot <= 1'b0;
        pg('{8'h01, 8'h07, 0, 8'h0B, 0, 0, 0, 0, 8'h00, 0, 0, 0}, 9, 1, 0);
        chk({rr, wrl}, 16'h0B0B);
        // Each unsupported flag alone must be refused
        for (int k = 0; k < 6; k++) begin
            if (k != 4) pg('{8'h01, 8'h07, 8'(1 << k), 0, 0, 0, 0, 0, 0, 0, 0, 0}, 9, 1, 1);
        end
        chk(senseKey, SENSE_ILLEGAL_REQ);
        pg('{8'h01, 8'h08, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}, 9, 1, 1);
        pg('{8'h02, 8'h0A, 8'hB0, 8'hA0, 0, 0, 0, 0, 0, 0, 0, 0}, 12, 1, 1);
        pg('{8'h02, 8'h0A, 8'h40, 8'h40, 0, 0, 0, 0, 0, 0, 0, 0}, 12, 0, 0);
        chk(fill, 8'h80);
        pg('{8'h02, 8'h0A, 8'h40, 8'h40, 0, 0, 8'h12, 0, 0, 0, 0, 0}, 12, 1, 0);
        chk({fill, empty, senseKey}, 20'h40400);
        pulse(OFS_CTRL, 1);
        pg('{8'h02, 8'h0A, 8'h30, 8'h30, 0, 0, 0, 0, 0, 0, 0, 0}, 12, 1, 0);
        chk({fill, noDisconnect}, 9'h141);
        pg('{8'h02, 8'h0A, 8'hB0, 8'hB0, 0, 0, 0, 0, 0, 0, 8'h00, 8'h04}, 12, 1, 0);
        chk({fill, burstSize, noDisconnect}, 25'h1600008);
        @(posedge sys_clk) senseReq <= 1'b1;
        senseCode <= PG_DR_CODE;
        @(posedge sys_clk) senseReq <= 1'b0;
        n = 0;
        repeat (16) begin
            @(posedge sys_clk);
            #1 if (senseValid === 1'b1 && n < 12) sb[n++] = senseByte;
        end
        // Disconnect time bytes read back as zero
        foreach (sb[k]) chk(sb[k], k == 0 ? 2 : k == 1 ? 8'h0A : k < 4 ? 8'hB0 : k == 11 ? 4 : 0);
        pulse(OFS_THRESH, 0);
        chk(rd, 32'h0004B0B0);
        pulse(4'h2, 0);
        chk(rd, 0);
        @(posedge sys_clk) readErr <= 1'b1;
        @(posedge sys_clk) readErr <= 1'b0;
        #1 chk(readRetry, 1);
        // Burst of 4 units: the 2048th byte ends the connection
        @(posedge sys_clk) {dataPhase, xferStrobe} <= 2'b11;
        repeat (2047) @(posedge sys_clk);
        #1 chk(disconnectReq, 0);
        @(posedge sys_clk) xferStrobe <= 1'b0;
        #1 chk(disconnectReq, 1);
        @(posedge sys_clk) {dataPhase, busReleased, bufFree} <= {2'b01, 8'hB0};
        @(posedge sys_clk) busReleased <= 1'b0;
        repeat (19) @(posedge sys_clk);
        #1 chk(reconnectReq, 0);
        @(posedge sys_clk);
        #1 chk(reconnectReq, 1);
        @(posedge sys_clk) bufFree <= 8'hAF;
        #1 chk(reconnectReq, 0);
        summarize();
    end
endmodule : test_mpe_mode_pages

// ==== verilog/mpe_mode_pages.sv ====
// Mode page engine: error recovery and disconnect-reconnect pages with bus policy
// Summary of operation
// RULE1: Apply pages only for page format selects
// RULE2: Error recovery page code is 01h
// RULE3: Error recovery page length is 07h
// RULE4: Host sends zero in unsupported flags
// RULE5: Read retries 00h..0Bh, default 0Bh
// RULE6: Write retry changes only at tape start
// RULE7: Write retry stored 00h or 0Bh
// RULE8: Zero write retries: never rewrite, continue
// RULE9: Zero-retry writing sets written-without-retries flag
// RULE10: Disconnect page code 02h, length 0Ah
// RULE11: Read reconnect at fill threshold times 4KB
// RULE12: Write reconnect at free space threshold
// RULE13: No-disconnect forces fill outside A0h..C0h to A0h
// RULE14: Empty threshold unequal to fill: reject
// RULE15: Bus inactivity limit only zero
// RULE16: Disconnect time limit fixed zero, reads zero
// RULE17: At least 265 us before reselection
// RULE18: Connect limit zero; disconnect after burst
// RULE19: Burst in 512-byte units, zero unlimited
// RULE20: Nonzero burst clears no-disconnect setting
// RULE21: No-disconnect keeps device connected during data
// RULE22: Bad code, length or fields: illegal request
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module mpe_mode_pages #(
    parameter int RESEL_CYCLES = mpe_pkg::RESEL_MIN_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic selValid,
    input wire logic [7:0] selByte,
    input wire logic selLast,
    input wire logic selPageFormat,
    output logic selDone,
    output logic selReject,
    output logic [3:0] senseKey,
    input wire logic senseReq,
    input wire logic [5:0] senseCode,
    output logic senseValid,
    output logic [7:0] senseByte,
    output logic senseLast,
    output logic senseReject,
    input wire logic logicalBeginningOfTape,
    input wire logic readErr,
    input wire logic readOk,
    output logic readRetry,
    output logic readFatal,
    input wire logic writeErr,
    input wire logic writeBlockDone,
    output logic writeRewrite,
    output logic writeSkip,
    output logic writeFatal,
    input wire logic dataPhase,
    input wire logic dirRead,
    input wire logic xferStrobe,
    input wire logic [7:0] bufFill,
    input wire logic [7:0] bufFree,
    input wire logic busReleased,
    input wire logic reselDone,
    output logic disconnectReq,
    output logic reconnectReq,
    output logic [7:0] readRetryLimit,
    output logic [7:0] writeRetryLimit,
    output logic [7:0] fillThreshold,
    output logic [7:0] emptyThreshold,
    output logic [15:0] burstSize,
    output logic noDisconnect,
    output logic writtenWithoutRetries
);
    import mpe_pkg::*;

    logic [7:0] pageBuf [0:11]; // Incoming page bytes
    logic [3:0] selCount_reg; // Bytes received so far
    logic commitPend_reg; // Evaluate page next cycle
    logic commitPf_reg; // Page format qualifier latched
    logic [3:0] commitLen_reg; // Bytes in the finished page
    logic ndReg; // No-disconnect setting
    logic [1:0] senseSel_reg; // 1 error page, 2 disconnect page
    logic [3:0] senseIdx_reg;
    logic [7:0] readTry_reg;
    logic [7:0] writeTry_reg;
    logic [24:0] burstBytes_reg; // Bytes moved since connect
    logic [15:0] resTimer_reg;
    mpe_dstate_e dState_reg;
    logic [7:0] fillClamp; // Fill threshold after clamp
    logic pageOk; // Page passes every check
    logic isErrPage;
    logic isDrPage;
    logic ndNext; // Setting after burst precedence
    logic [7:0] senseByte_next;
    logic burstHit;

    // Collect bytes; a new page overwrites the previous one
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            selCount_reg <= 4'h0;
            commitPend_reg <= 1'b0;
            commitPf_reg <= 1'b0;
            commitLen_reg <= 4'h0;
        end else begin
            commitPend_reg <= selValid & selLast;
            if (selValid) begin
                // Overlong pages wrap the counter, so only the length modulo 16 is checked
                selCount_reg <= selLast ? 4'h0 : selCount_reg + 4'h1;
                if (selLast) begin
                    commitPf_reg <= selPageFormat;
                    commitLen_reg <= selCount_reg + 4'h1;
                end
            end
        end
    end

    // Page storage array, no reset needed for data
    always_ff @(posedge sys_clk) begin
        if (selValid && selCount_reg < 4'hC) begin
            pageBuf[selCount_reg] <= selByte;
        end
    end

    // Page checks
    always_comb begin
        isErrPage = pageBuf[B_CODE][5:0] == PG_ERR_CODE; // RULE2
        isDrPage = pageBuf[B_CODE][5:0] == PG_DR_CODE; // RULE10
        pageOk = 1'b0;
        if (isErrPage) begin
            // Length byte, byte count, unsupported flags, retry range
            pageOk = pageBuf[B_LEN] == PG_ERR_LEN && commitLen_reg == PG_ERR_BYTES // RULE3
                && pageBuf[B_FLAGS][F_TRANSFER_BLOCK] == 1'b0 // RULE4
                && pageBuf[B_FLAGS][F_EARLY_RECOVERY] == 1'b0
                && pageBuf[B_FLAGS][F_POST_ERROR] == 1'b0
                && pageBuf[B_FLAGS][F_STOP_ON_ERROR] == 1'b0
                && pageBuf[B_FLAGS][F_CORRECTION_DISABLE] == 1'b0
                && pageBuf[B_RRETRY] <= RETRY_MAX; // RULE5
        end else if (isDrPage) begin
            // Disconnect time bytes 6..7 are ignored on purpose
            pageOk = pageBuf[B_LEN] == PG_DR_LEN && commitLen_reg == PG_DR_BYTES // RULE10
                && pageBuf[B_FULL] >= THR_MIN && pageBuf[B_FULL] <= THR_MAX // RULE11
                && pageBuf[B_EMPTY] == pageBuf[B_FULL] // RULE14
                && pageBuf[B_INACT] == 8'h00 && pageBuf[B_INACT + 1] == 8'h00 // RULE15
                && pageBuf[B_CONN] == 8'h00 && pageBuf[B_CONN + 1] == 8'h00; // RULE18
        end
        // Burst wins over the no-disconnect setting
        ndNext = ndReg & ({pageBuf[B_BURST], pageBuf[B_BURST + 1]} == 16'h0000); // RULE20
        fillClamp = pageBuf[B_FULL];
        if (ndNext && (fillClamp < ND_THR_MIN || fillClamp > ND_THR_MAX)) begin
            fillClamp = ND_THR_MIN; // RULE13
        end
    end

    // Select result: non page format data is consumed and ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            selDone <= 1'b0;
            selReject <= 1'b0;
            senseKey <= SENSE_NONE;
        end else begin
            selDone <= commitPend_reg;
            selReject <= commitPend_reg & commitPf_reg & ~pageOk; // RULE22
            if (commitPend_reg && commitPf_reg) begin
                senseKey <= pageOk ? SENSE_NONE : SENSE_ILLEGAL_REQ; // RULE14
            end
        end
    end

    // Error recovery limits
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            readRetryLimit <= RETRY_MAX;
            writeRetryLimit <= RETRY_MAX;
        end else if (commitPend_reg && commitPf_reg && pageOk && isErrPage) begin // RULE1
            readRetryLimit <= pageBuf[B_RRETRY]; // RULE5
            if (logicalBeginningOfTape) begin // RULE6
                // Any nonzero request becomes the full count
                writeRetryLimit <= (pageBuf[B_WRETRY] == 8'h00) ? 8'h00 : RETRY_MAX; // RULE7
            end
        end
    end

    // Disconnect-reconnect values and the no-disconnect setting
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fillThreshold <= THR_DEFAULT;
            emptyThreshold <= THR_DEFAULT;
            burstSize <= BURST_DEFAULT;
            ndReg <= 1'b0;
        end else if (commitPend_reg && commitPf_reg && pageOk && isDrPage) begin // RULE1
            fillThreshold <= fillClamp; // RULE13
            emptyThreshold <= fillClamp;
            burstSize <= {pageBuf[B_BURST], pageBuf[B_BURST + 1]}; // RULE19
            ndReg <= ndNext; // RULE20
        end else if (regWr && regAddr == OFS_CTRL) begin
            // Setting is refused while a burst limit is in force
            ndReg <= regWrData[CTRL_ND_BIT] & (burstSize == 16'h0000); // RULE20
            if (regWrData[CTRL_ND_BIT] && burstSize == 16'h0000
                && (fillThreshold < ND_THR_MIN || fillThreshold > ND_THR_MAX)) begin
                fillThreshold <= ND_THR_MIN; // RULE13
                emptyThreshold <= ND_THR_MIN;
            end
        end
    end
    assign noDisconnect = ndReg;

    // Written-without-retries flag; a new event beats a software clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            writtenWithoutRetries <= 1'b0;
        end else if (writeBlockDone && writeRetryLimit == 8'h00) begin
            writtenWithoutRetries <= 1'b1; // RULE9
        end else if (regWr && regAddr == OFS_STATUS && regWrData[STAT_WWR_BIT]) begin
            writtenWithoutRetries <= 1'b0;
        end
    end

    // Read recovery attempts
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            readTry_reg <= 8'h00;
            readRetry <= 1'b0;
            readFatal <= 1'b0;
        end else begin
            readRetry <= readErr & (readTry_reg < readRetryLimit); // RULE5
            readFatal <= readErr & (readTry_reg >= readRetryLimit);
            if (readOk || (readErr && readTry_reg >= readRetryLimit)) begin
                readTry_reg <= 8'h00;
            end else if (readErr) begin
                readTry_reg <= readTry_reg + 8'h01;
            end
        end
    end

    // Write rewrite attempts; zero limit just keeps writing
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            writeTry_reg <= 8'h00;
            writeRewrite <= 1'b0;
            writeSkip <= 1'b0;
            writeFatal <= 1'b0;
        end else begin
            writeSkip <= writeErr & (writeRetryLimit == 8'h00); // RULE8
            writeRewrite <= writeErr & (writeRetryLimit != 8'h00) & (writeTry_reg < writeRetryLimit);
            writeFatal <= writeErr & (writeRetryLimit != 8'h00) & (writeTry_reg >= writeRetryLimit);
            if (writeBlockDone || (writeErr && writeTry_reg >= writeRetryLimit)) begin
                writeTry_reg <= 8'h00;
            end else if (writeErr) begin
                writeTry_reg <= writeTry_reg + 8'h01;
            end
        end
    end

    // Mode sense byte source; fixed fields read as zero
    always_comb begin
        senseByte_next = 8'h00; // RULE16
        if (senseSel_reg == 2'b01) begin
            case (senseIdx_reg)
                4'h0: senseByte_next = {2'b00, PG_ERR_CODE};
                4'h1: senseByte_next = PG_ERR_LEN;
                4'h3: senseByte_next = readRetryLimit;
                4'h8: senseByte_next = writeRetryLimit;
                default: senseByte_next = 8'h00;
            endcase
        end else begin
            case (senseIdx_reg)
                4'h0: senseByte_next = {2'b00, PG_DR_CODE};
                4'h1: senseByte_next = PG_DR_LEN;
                4'h2: senseByte_next = fillThreshold;
                4'h3: senseByte_next = emptyThreshold;
                4'hA: senseByte_next = burstSize[15:8];
                4'hB: senseByte_next = burstSize[7:0];
                default: senseByte_next = 8'h00;
            endcase
        end
    end

    // Mode sense sequencer, one byte per cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            senseSel_reg <= 2'b00;
            senseIdx_reg <= 4'h0;
            senseValid <= 1'b0;
            senseByte <= 8'h00;
            senseLast <= 1'b0;
            senseReject <= 1'b0;
        end else begin
            senseReject <= senseReq && senseSel_reg == 2'b00
                && senseCode != PG_ERR_CODE && senseCode != PG_DR_CODE; // RULE22
            senseValid <= senseSel_reg != 2'b00;
            senseByte <= senseSel_reg != 2'b00 ? senseByte_next : 8'h00;
            senseLast <= 1'b0;
            if (senseSel_reg != 2'b00) begin
                if (senseIdx_reg == (senseSel_reg == 2'b01 ? PG_ERR_BYTES : PG_DR_BYTES) - 4'h1) begin
                    senseLast <= 1'b1;
                    senseSel_reg <= 2'b00;
                    senseIdx_reg <= 4'h0;
                end else begin
                    senseIdx_reg <= senseIdx_reg + 4'h1;
                end
            end else if (senseReq && senseCode == PG_ERR_CODE) begin
                senseSel_reg <= 2'b01;
            end else if (senseReq && senseCode == PG_DR_CODE) begin
                senseSel_reg <= 2'b10;
            end
        end
    end

    // Burst limit reached: bytes moved equal size times 512 minus one, so this strobe ends the burst
    assign burstHit = burstSize != 16'h0000
        && burstBytes_reg == {burstSize, 9'h000} - 25'h0000001; // RULE19

    // Connection state: disconnect, wait minimum time, ask to reselect
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dState_reg <= DS_CONN;
            burstBytes_reg <= 25'h0000000;
            resTimer_reg <= 16'h0000;
            disconnectReq <= 1'b0;
        end else begin
            disconnectReq <= 1'b0;
            case (dState_reg)
                DS_CONN: begin
                    if (!dataPhase) begin
                        burstBytes_reg <= 25'h0000000;
                    end else if (xferStrobe) begin
                        burstBytes_reg <= burstBytes_reg + 25'h0000001;
                    end
                    // Without a burst limit an empty buffer on reads or a full buffer on writes ends the burst
                    if (dataPhase && !ndReg && ((xferStrobe && burstHit) // RULE18
                        || (burstSize == 16'h0000 && (dirRead ? bufFill == 8'h00 : bufFree == 8'h00)))) begin
                        disconnectReq <= 1'b1; // RULE21
                    end
                    if (busReleased) begin
                        dState_reg <= DS_WAIT;
                        resTimer_reg <= 16'h0000;
                    end
                end
                DS_WAIT: begin
                    // Reselection must not start too soon after release
                    if (resTimer_reg == 16'(RESEL_CYCLES - 1)) begin // RULE17
                        dState_reg <= DS_READY;
                    end else begin
                        resTimer_reg <= resTimer_reg + 16'h0001;
                    end
                end
                DS_READY: begin
                    if (reselDone) begin
                        dState_reg <= DS_CONN;
                        burstBytes_reg <= 25'h0000000;
                    end
                end
                default: dState_reg <= DS_CONN;
            endcase
        end
    end

    // Reconnect once buffer fill or free space reaches the threshold
    assign reconnectReq = dState_reg == DS_READY
        && (dirRead ? bufFill >= fillThreshold : bufFree >= emptyThreshold); // RULE11 RULE12

    // Register reads, data only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 32'h00000000;
        end else if (!regRd) begin
            regRdData <= 32'h00000000;
        end else if (regAddr == OFS_CTRL) begin
            regRdData <= {31'h00000000, ndReg};
        end else if (regAddr == OFS_STATUS) begin
            regRdData <= {20'h00000, senseKey, 5'h00, selReject, logicalBeginningOfTape, writtenWithoutRetries};
        end else if (regAddr == OFS_LIMITS) begin
            regRdData <= {16'h0000, writeRetryLimit, readRetryLimit};
        end else if (regAddr == OFS_THRESH) begin
            regRdData <= {burstSize, emptyThreshold, fillThreshold};
        end else begin
            regRdData <= 32'h00000000;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [15:0] sinceRel_reg; // Cycles since last bus release
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sinceRel_reg <= 16'h0000;
        end else if (busReleased && dState_reg == DS_CONN) begin
            sinceRel_reg <= 16'h0000;
        end else if (sinceRel_reg != 16'hFFFF) begin
            sinceRel_reg <= sinceRel_reg + 16'h0001;
        end
    end

    sequence s_nonPfPage;
        selValid && selLast && !selPageFormat;
    endsequence
    sequence s_mismatch;
        selValid && selLast && selPageFormat && selCount_reg == 4'hB
            && pageBuf[B_CODE][5:0] == PG_DR_CODE && pageBuf[B_EMPTY] != pageBuf[B_FULL];
    endsequence

    property p_pfOnly;
        s_nonPfPage |-> ##2 (selDone && !selReject && $stable(readRetryLimit) && $stable(burstSize));
    endproperty
    a_pfOnly: assert property (p_pfOnly) else $error("non page format select changed state"); // RULE1
    property p_readRange;
        readRetryLimit <= RETRY_MAX;
    endproperty
    a_readRange: assert property (p_readRange) else $error("read retry limit out of range"); // RULE5
    property p_writeBot;
        $changed(writeRetryLimit) |-> $past(logicalBeginningOfTape)
            && (writeRetryLimit == 8'h00 || writeRetryLimit == RETRY_MAX);
    endproperty
    a_writeBot: assert property (p_writeBot) else $error("write retry limit changed away from start"); // RULE6
    property p_skip;
        writeErr && writeRetryLimit == 8'h00 |=> writeSkip && !writeRewrite && !writeFatal;
    endproperty
    a_skip: assert property (p_skip) else $error("zero write retry limit caused rewrite"); // RULE8
    property p_wwr;
        writeBlockDone && writeRetryLimit == 8'h00 |=> writtenWithoutRetries;
    endproperty
    a_wwr: assert property (p_wwr) else $error("written without retries flag not set"); // RULE9
    property p_ndClamp;
        noDisconnect |-> fillThreshold >= ND_THR_MIN && fillThreshold <= ND_THR_MAX;
    endproperty
    a_ndClamp: assert property (p_ndClamp) else $error("fill threshold outside no-disconnect window"); // RULE13
    property p_mismatch;
        s_mismatch |-> ##2 (selReject && senseKey == SENSE_ILLEGAL_REQ);
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("unequal thresholds not rejected"); // RULE14
    property p_resel;
        reconnectReq |-> sinceRel_reg >= 16'(RESEL_CYCLES);
    endproperty
    a_resel: assert property (p_resel) else $error("reconnect requested too early"); // RULE17
    property p_burstNd;
        burstSize != 16'h0000 |-> !noDisconnect;
    endproperty
    a_burstNd: assert property (p_burstNd) else $error("burst limit with no-disconnect set"); // RULE20
    property p_ndHold;
        noDisconnect |=> !disconnectReq;
    endproperty
    a_ndHold: assert property (p_ndHold) else $error("disconnect while no-disconnect set"); // RULE21
endmodule : mpe_mode_pages

// ==== verilog/mpe_pkg.sv ====
// Constants for the error recovery and disconnect-reconnect mode page engine
package mpe_pkg;
    // Page identities and lengths
    localparam logic [5:0] PG_ERR_CODE = 6'h01;
    localparam logic [7:0] PG_ERR_LEN = 8'h07;
    localparam logic [5:0] PG_DR_CODE = 6'h02;
    localparam logic [7:0] PG_DR_LEN = 8'h0A;
    localparam logic [3:0] PG_ERR_BYTES = 4'h9;
    localparam logic [3:0] PG_DR_BYTES = 4'hC;
    // Byte positions inside the pages
    localparam int B_CODE = 0;
    localparam int B_LEN = 1;
    localparam int B_FLAGS = 2;
    localparam int B_RRETRY = 3;
    localparam int B_WRETRY = 8;
    localparam int B_FULL = 2;
    localparam int B_EMPTY = 3;
    localparam int B_INACT = 4;
    localparam int B_CONN = 8;
    localparam int B_BURST = 10;
    // Unsupported flag bits of the error recovery page, all must be zero
    localparam int F_TRANSFER_BLOCK = 5;
    localparam int F_EARLY_RECOVERY = 3;
    localparam int F_POST_ERROR = 2;
    localparam int F_STOP_ON_ERROR = 1;
    localparam int F_CORRECTION_DISABLE = 0;
    // Defaults and legal ranges
    localparam logic [7:0] RETRY_MAX = 8'h0B;
    localparam logic [7:0] THR_DEFAULT = 8'h80;
    localparam logic [7:0] THR_MIN = 8'h20;
    localparam logic [7:0] THR_MAX = 8'hD0;
    localparam logic [7:0] ND_THR_MIN = 8'hA0;
    localparam logic [7:0] ND_THR_MAX = 8'hC0;
    localparam logic [15:0] BURST_DEFAULT = 16'h0000;
    localparam logic [3:0] SENSE_ILLEGAL_REQ = 4'h5;
    localparam logic [3:0] SENSE_NONE = 4'h0;
    localparam int BURST_UNIT_LOG2 = 9;
    // Register offsets and fields
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_LIMITS = 4'h8;
    localparam logic [3:0] OFS_THRESH = 4'hC;
    localparam int CTRL_ND_BIT = 0;
    localparam int STAT_WWR_BIT = 0;
    localparam int STAT_BOT_BIT = 1;
    localparam int STAT_REJ_BIT = 2;
    localparam int STAT_KEY_LSB = 8;
    // Minimum gap between disconnect and reselection
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESEL_MIN_NS = 265000;
    localparam int RESEL_MIN_CYC = (RESEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Bus connection state
    typedef enum logic [1:0] {
        DS_CONN = 2'b00,
        DS_WAIT = 2'b01,
        DS_READY = 2'b10
    } mpe_dstate_e;
endpackage : mpe_pkg
